// ### inc/porp_pkg.sv
// Shared constants, types and helpers of the PWM output, reload and prescale block.
`default_nettype none
package porp_pkg;
   localparam int CNT_W = 16;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int NUM_PAIRS = 3;
   localparam int SEL_W = 2;
   localparam int PERIODS_W = 4;

   localparam logic [ADDR_W-1:0] OFS_WAVE_CTL0 = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_WAVE_CTL1 = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_DEADBAND = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_DUTY0 = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_STRIDE = 8'h04;

   localparam int CTL0_RUN = 0;
   localparam int CTL0_READY = 1;
   localparam int CTL0_ACTIVE = 2;
   localparam int CTL0_MOTOR_OUTPUT_ENABLE_OPTION = 3;
   localparam int CTL1_RATE_LSB = 0;
   localparam int CTL1_CLOCK_DIVIDE_SELECT_LSB = 2;
   localparam int CTL1_CENTER = 4;

   localparam int OPT_HI = 0;
   localparam int OPT_LO = 1;
   localparam int OPT_EN = 2;
   localparam int OPT_W = 3;

   localparam logic [SEL_W-1:0] SEL_DIV4 = 2'h2;
   localparam logic [SEL_W-1:0] SEL_RATE8 = 2'h3;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] PERIOD_RST = 16'h00ff;

   typedef enum logic [1:0] {
      ST_HIZ = 2'b00,
      ST_OFF = 2'b01,
      ST_RUN = 2'b11,
      ST_DIS = 2'b10
   } porp_state_t;

   typedef struct packed {
      logic center;
      logic [SEL_W-1:0] clock_divide_select;
      logic [SEL_W-1:0] rate;
      logic [CNT_W-1:0] db;
      logic [NUM_PAIRS-1:0][CNT_W-1:0] duty;
      logic [CNT_W-1:0] period;
   } porp_timing_t;

   localparam porp_timing_t TIMING_RST = '{
      center: 1'b0,
      clock_divide_select: 2'h0,
      rate: 2'h0,
      db: 16'h0000,
      duty: '0,
      period: PERIOD_RST
   };

   // A two-bit select picks a factor of 1, 2, 4 or 8.
   function automatic logic [PERIODS_W-1:0] porp_pow2(input logic [SEL_W-1:0] sel);
      return 4'h1 << sel;
   endfunction

   function automatic logic [ADDR_W-1:0] porp_duty_ofs(input int idx);
      return OFS_DUTY0 + 8'(idx) * OFS_STRIDE;
   endfunction
endpackage
`default_nettype wire

// ### rtl/porp_prescale.sv
// Clock prescaler that makes the PWM counting tick from the system clock.
`timescale 1ns/100ps
`default_nettype none
module porp_prescale #(
   parameter int DIV_W = 4
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic run_in,
   input wire logic [porp_pkg::SEL_W-1:0] div_sel_in,
   output logic tick_out
);
   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] div_w;

   assign div_w = DIV_W'(porp_pkg::porp_pow2(div_sel_in));

   always_ff @(posedge core_clk_in) begin
      if (rst_in || !run_in) begin
         cnt_q <= '0;
         tick_out <= 1'b0;
      end else if (cnt_q >= DIV_W'(div_w - 1'b1)) begin
         cnt_q <= '0;
         tick_out <= 1'b1;
      end else begin
         cnt_q <= DIV_W'(cnt_q + 1'b1);
         tick_out <= 1'b0;
      end
   end

   a_div_four: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (tick_out && div_sel_in == porp_pkg::SEL_DIV4) ##1
      (run_in && div_sel_in == porp_pkg::SEL_DIV4)[*4] |->
      tick_out && !$past(tick_out, 1) && !$past(tick_out, 2) && !$past(tick_out, 3))
      else $error("prescaler tick spacing wrong for divide by four");
endmodule
`default_nettype wire

// ### rtl/porp_chan.sv
// Compare logic of one complementary output pair with deadband.
`timescale 1ns/100ps
`default_nettype none
module porp_chan (
   input wire logic [porp_pkg::CNT_W-1:0] cnt_in,
   input wire logic [porp_pkg::CNT_W-1:0] duty_in,
   input wire logic [porp_pkg::CNT_W-1:0] db_in,
   output logic hi_act_out,
   output logic lo_act_out
);
   logic [porp_pkg::CNT_W:0] lo_edge;

   // The sum is one bit wider so a large deadband cannot wrap into an overlap.
   assign lo_edge = {1'b0, duty_in} + {1'b0, db_in};
   assign hi_act_out = cnt_in < duty_in;
   assign lo_act_out = {1'b0, cnt_in} >= lo_edge;
endmodule
`default_nettype wire

// ### rtl/porp_top.sv
// PWM output state, enable, buffered reload and prescale block.
`timescale 1ns/100ps
`default_nettype none
module porp_top (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [porp_pkg::ADDR_W-1:0] addr_in,
   input wire logic [porp_pkg::DATA_W-1:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [porp_pkg::DATA_W-1:0] rd_data_out,
   input wire logic high_side_off_level_option_in,
   input wire logic low_side_off_level_option_in,
   input wire logic motor_output_enable_option_in,
   output logic [porp_pkg::NUM_PAIRS-1:0] high_side_out,
   output logic [porp_pkg::NUM_PAIRS-1:0] high_side_oe_out,
   output logic [porp_pkg::NUM_PAIRS-1:0] low_side_out,
   output logic [porp_pkg::NUM_PAIRS-1:0] low_side_oe_out
);
   localparam int NP = porp_pkg::NUM_PAIRS;
   localparam int CW = porp_pkg::CNT_W;

   logic [porp_pkg::OPT_W-1:0] opt_meta_q;
   logic [porp_pkg::OPT_W-1:0] opt_sync_q;
   logic off_hi_q;
   logic off_lo_q;
   logic mc_en_q;
   porp_pkg::porp_state_t state_q;
   porp_pkg::porp_state_t state_d;
   logic run_en_q;
   logic ready_q;
   porp_pkg::porp_timing_t shadow_q;
   porp_pkg::porp_timing_t active_q;
   logic [CW-1:0] cnt_q;
   logic dir_down_q;
   logic [porp_pkg::PERIODS_W-1:0] periods_q;
   logic tick;
   logic period_end;
   logic reload;
   logic running;
   logic drive;
   logic wr_ctl0;
   logic [NP-1:0] hi_act;
   logic [NP-1:0] lo_act;
   logic [porp_pkg::DATA_W-1:0] rd_d;

   assign running = state_q == porp_pkg::ST_RUN;
   assign drive = state_q == porp_pkg::ST_OFF || running;
   assign wr_ctl0 = wr_in && addr_in == porp_pkg::OFS_WAVE_CTL0;

   // Option straps come from outside the clock domain, so they are synchronised first.
   always_ff @(posedge core_clk_in) begin
      opt_meta_q <= {motor_output_enable_option_in, low_side_off_level_option_in,
                     high_side_off_level_option_in};
      opt_sync_q <= opt_meta_q;
   end

   // Options are caught once, in the first cycle after reset is released.
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         off_hi_q <= 1'b0;
         off_lo_q <= 1'b0;
         mc_en_q <= 1'b0;
      end else if (state_q == porp_pkg::ST_HIZ) begin
         off_hi_q <= opt_sync_q[porp_pkg::OPT_HI];
         off_lo_q <= opt_sync_q[porp_pkg::OPT_LO];
         mc_en_q <= opt_sync_q[porp_pkg::OPT_EN];
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         porp_pkg::ST_HIZ: begin
            state_d = opt_sync_q[porp_pkg::OPT_EN] ? porp_pkg::ST_OFF : porp_pkg::ST_DIS;
         end
         porp_pkg::ST_OFF: begin
            if (run_en_q) begin
               state_d = porp_pkg::ST_RUN;
            end
         end
         porp_pkg::ST_RUN: begin
            if (!run_en_q) begin
               state_d = porp_pkg::ST_OFF;
            end
         end
         porp_pkg::ST_DIS: begin
            state_d = porp_pkg::ST_DIS;
         end
         default: begin
            state_d = porp_pkg::ST_HIZ;
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         state_q <= porp_pkg::ST_HIZ;
      end else begin
         state_q <= state_d;
      end
   end

   // Writes store shadow values only; nothing here touches the live timing.
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         shadow_q <= porp_pkg::TIMING_RST;
      end else if (wr_in) begin
         case (addr_in)
            porp_pkg::OFS_WAVE_CTL1: begin
               shadow_q.rate <= wr_data_in[porp_pkg::CTL1_RATE_LSB +: porp_pkg::SEL_W];
               shadow_q.clock_divide_select <= wr_data_in[porp_pkg::CTL1_CLOCK_DIVIDE_SELECT_LSB +: porp_pkg::SEL_W];
               shadow_q.center <= wr_data_in[porp_pkg::CTL1_CENTER];
            end
            porp_pkg::OFS_PERIOD: begin
               shadow_q.period <= wr_data_in;
            end
            porp_pkg::OFS_DEADBAND: begin
               shadow_q.db <= wr_data_in;
            end
            default: begin
               for (int i = 0; i < NP; i++) begin
                  if (addr_in == porp_pkg::porp_duty_ofs(i)) begin
                     shadow_q.duty[i] <= wr_data_in;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         run_en_q <= 1'b0;
         ready_q <= 1'b0;
      end else if (wr_ctl0) begin
         run_en_q <= wr_data_in[porp_pkg::CTL0_RUN];
         ready_q <= wr_data_in[porp_pkg::CTL0_READY];
      end else if (reload) begin
         ready_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         active_q <= porp_pkg::TIMING_RST;
      end else if (reload && ready_q) begin
         active_q <= shadow_q;
      end
   end

   porp_prescale #(
      .DIV_W(porp_pkg::PERIODS_W)
   ) u_prescale (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .run_in(running),
      .div_sel_in(active_q.clock_divide_select),
      .tick_out(tick)
   );

   always_comb begin
      if (!active_q.center) begin
         period_end = tick && cnt_q >= active_q.period;
      end else begin
         period_end = tick && dir_down_q && cnt_q == porp_pkg::CNT_ONE;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in || !running) begin
         cnt_q <= porp_pkg::CNT_ZERO;
         dir_down_q <= 1'b0;
      end else if (tick) begin
         if (!active_q.center) begin
            cnt_q <= period_end ? porp_pkg::CNT_ZERO : CW'(cnt_q + porp_pkg::CNT_ONE);
            dir_down_q <= 1'b0;
         end else if (dir_down_q) begin
            cnt_q <= CW'(cnt_q - porp_pkg::CNT_ONE);
            dir_down_q <= cnt_q != porp_pkg::CNT_ONE;
         end else if (cnt_q >= active_q.period && cnt_q != porp_pkg::CNT_ZERO) begin
            cnt_q <= CW'(cnt_q - porp_pkg::CNT_ONE);
            dir_down_q <= 1'b1;
         end else if (cnt_q < active_q.period) begin
            cnt_q <= CW'(cnt_q + porp_pkg::CNT_ONE);
         end
      end
   end

   assign reload = period_end &&
      periods_q == 4'(porp_pkg::porp_pow2(active_q.rate) - 4'h1);

   always_ff @(posedge core_clk_in) begin
      if (rst_in || !running) begin
         periods_q <= '0;
      end else if (reload) begin
         periods_q <= '0;
      end else if (period_end) begin
         periods_q <= 4'(periods_q + 4'h1);
      end
   end

   genvar g;
   generate
      for (g = 0; g < NP; g++) begin : g_pair
         porp_chan u_chan (
            .cnt_in(cnt_q),
            .duty_in(active_q.duty[g]),
            .db_in(active_q.db),
            .hi_act_out(hi_act[g]),
            .lo_act_out(lo_act[g])
         );
      end
   endgenerate

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         high_side_out <= '0;
         low_side_out <= '0;
         high_side_oe_out <= '0;
         low_side_oe_out <= '0;
      end else begin
         for (int i = 0; i < NP; i++) begin
            high_side_out[i] <= drive && ((running && hi_act[i]) ? !off_hi_q : off_hi_q);
            low_side_out[i] <= drive && ((running && lo_act[i]) ? !off_lo_q : off_lo_q);
         end
         high_side_oe_out <= {NP{drive}};
         low_side_oe_out <= {NP{drive}};
      end
   end

   // Timing reads show the shadow values, so software sees what it wrote, not what is live; count and active bit read live.
   always_comb begin
      rd_d = '0;
      case (addr_in)
         porp_pkg::OFS_WAVE_CTL0: begin
            rd_d[porp_pkg::CTL0_RUN] = run_en_q;
            rd_d[porp_pkg::CTL0_READY] = ready_q;
            rd_d[porp_pkg::CTL0_ACTIVE] = running;
            rd_d[porp_pkg::CTL0_MOTOR_OUTPUT_ENABLE_OPTION] = mc_en_q;
         end
         porp_pkg::OFS_WAVE_CTL1: begin
            rd_d[porp_pkg::CTL1_RATE_LSB +: porp_pkg::SEL_W] = shadow_q.rate;
            rd_d[porp_pkg::CTL1_CLOCK_DIVIDE_SELECT_LSB +: porp_pkg::SEL_W] = shadow_q.clock_divide_select;
            rd_d[porp_pkg::CTL1_CENTER] = shadow_q.center;
         end
         porp_pkg::OFS_PERIOD: begin
            rd_d = shadow_q.period;
         end
         porp_pkg::OFS_DEADBAND: begin
            rd_d = shadow_q.db;
         end
         porp_pkg::OFS_COUNT: begin
            rd_d = cnt_q;
         end
         default: begin
            for (int i = 0; i < NP; i++) begin
               if (addr_in == porp_pkg::porp_duty_ofs(i)) begin
                  rd_d = shadow_q.duty[i];
               end
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         rd_data_out <= '0;
      end else begin
         rd_data_out <= rd_in ? rd_d : '0;
      end
   end

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);

   a_reset_hiz: assert property (disable iff (1'b0) rst_in |=>
      high_side_oe_out == '0 && low_side_oe_out == '0)
      else $error("pins driven right after reset");

   a_disabled_hiz: assert property (!mc_en_q && state_q != porp_pkg::ST_HIZ |->
      high_side_oe_out == '0 && low_side_oe_out == '0)
      else $error("pins driven without motor enable");

   a_enabled_drive: assert property (state_q == porp_pkg::ST_OFF |=>
      high_side_oe_out == {NP{1'b1}} && low_side_oe_out == {NP{1'b1}} && mc_en_q)
      else $error("enabled pairs not driven");

   a_high_idle: assert property (state_q == porp_pkg::ST_OFF |=>
      high_side_out == {NP{off_hi_q}})
      else $error("high side not at off level");

   a_low_idle: assert property (state_q == porp_pkg::ST_OFF |=>
      low_side_out == {NP{off_lo_q}})
      else $error("low side not at off level");

   a_apply_shadow: assert property (reload && ready_q |=>
      active_q == $past(shadow_q) && periods_q == '0)
      else $error("ready values not applied at reload");

   a_hold_values: assert property (reload && !ready_q |=> $stable(active_q))
      else $error("active values changed without ready");

   a_reload_only: assert property ($changed(active_q) |->
      $past(reload) && $past(ready_q))
      else $error("active values changed outside reload");

   a_clock_divide_select_buffered: assert property ($changed(active_q.clock_divide_select) |->
      $past(reload))
      else $error("prescale changed outside reload");

   a_reload_rate: assert property (running |->
      periods_q < porp_pkg::porp_pow2(active_q.rate))
      else $error("period count passed the reload rate");

   a_center_turn: assert property (running && tick && active_q.center && !dir_down_q &&
      cnt_q >= active_q.period && cnt_q != porp_pkg::CNT_ZERO |=> dir_down_q)
      else $error("center count did not turn down");

   a_pair_overlap: assert property (running |=>
      ((high_side_out ^ {NP{off_hi_q}}) & (low_side_out ^ {NP{off_lo_q}})) == '0)
      else $error("both sides of a pair active");

   c_ready_reload: cover property (reload && ready_q);
   c_center_run: cover property (running && active_q.center && period_end);
   c_rate_eight: cover property (reload && active_q.rate == porp_pkg::SEL_RATE8);
   c_disabled: cover property (state_q == porp_pkg::ST_DIS);
endmodule
`default_nettype wire

// ### verif/porp_stage_model.sv
// Gate-driver stage model that resolves the six pins and flags shoot-through.
`timescale 1ns/100ps
`default_nettype none
module porp_stage_model (
   input wire logic core_clk_in,
   input wire logic [2:0] hi_in,
   input wire logic [2:0] hi_oe_in,
   input wire logic [2:0] lo_in,
   input wire logic [2:0] lo_oe_in,
   input wire logic hi_idle_in,
   input wire logic lo_idle_in,
   output logic [2:0] hi_pin_out,
   output logic [2:0] lo_pin_out,
   output logic shoot_out
);
   logic [2:0] hi_last_q = 3'h0;
   logic [2:0] lo_last_q = 3'h0;
   // Gate inputs have no pull, so a released pin must not keep its old level.
   always_ff @(posedge core_clk_in) begin
      hi_last_q <= hi_pin_out;
      lo_last_q <= lo_pin_out;
   end
   assign hi_pin_out = (hi_oe_in & hi_in) | (~hi_oe_in & ~hi_last_q);
   assign lo_pin_out = (lo_oe_in & lo_in) | (~lo_oe_in & ~lo_last_q);
   // Both switches of one leg on at once would short the supply.
   assign shoot_out = |((hi_pin_out ^ {3{hi_idle_in}}) & (lo_pin_out ^ {3{lo_idle_in}})
                        & hi_oe_in & lo_oe_in);
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the PWM output, reload and prescale block.
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic hi_opt = 1'b0;
   logic lo_opt = 1'b0;
   logic en_opt = 1'b1;
   logic [15:0] rdata;
   logic [2:0] hs, hs_oe, ls, ls_oe, hp, lp;
   logic shoot;
   int fails = 0;
   int compares = 0;
   int cyc = 0;
   int cfg[8];
   int pend[8];
   always #10 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) cyc <= cyc + 1;
   porp_top u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr),
      .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(rdata),
      .high_side_off_level_option_in(hi_opt), .low_side_off_level_option_in(lo_opt),
      .motor_output_enable_option_in(en_opt), .high_side_out(hs), .high_side_oe_out(hs_oe),
      .low_side_out(ls), .low_side_oe_out(ls_oe));
   porp_stage_model u_stage (.core_clk_in(core_clk_in), .hi_in(hs), .hi_oe_in(hs_oe),
      .lo_in(ls), .lo_oe_in(ls_oe), .hi_idle_in(hi_opt), .lo_idle_in(lo_opt),
      .hi_pin_out(hp), .lo_pin_out(lp), .shoot_out(shoot));
   task automatic give_verdict();
      if (fails == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t %s: got %0h want %0h", $time, msg, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk_in);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge core_clk_in);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge core_clk_in);
      rd <= 1'b1;
      addr <= a;
      @(posedge core_clk_in);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // The ready flag dropping is the only visible mark of a reload.
   task automatic wait_reload(output int t);
      logic [15:0] d;
      for (int i = 0; i < 400; i++) begin
         rd_reg(porp_pkg::OFS_WAVE_CTL0, d);
         if (d[porp_pkg::CTL0_READY] === 1'b0) begin
            t = cyc;
            return;
         end
      end
      fails++;
      give_verdict();
   endtask
   // Order: period, deadband, three duties, rate, divide, center.
   task automatic load(input int c[8]);
      pend = c;
      wr_reg(porp_pkg::OFS_PERIOD, 16'(c[0]));
      wr_reg(porp_pkg::OFS_DEADBAND, 16'(c[1]));
      for (int i = 0; i < 3; i++) begin
         wr_reg(porp_pkg::OFS_DUTY0 + 8'(4 * i), 16'(c[2 + i]));
      end
      wr_reg(porp_pkg::OFS_WAVE_CTL1, 16'(c[5] | (c[6] << 2) | (c[7] << 4)));
   endtask
   task automatic apply(output int t);
      wr_reg(porp_pkg::OFS_WAVE_CTL0, 16'h0003);
      wait_reload(t);
      cfg = pend;
   endtask
   // Whole periods are counted, so the phase of the window does not matter.
   task automatic meas();
      int dv, len, k, ov;
      int ha[3];
      int la[3];
      dv = 1 << cfg[6];
      len = (cfg[7] != 0) ? 2 * cfg[0] : cfg[0] + 1;
      ha = '{0, 0, 0};
      la = '{0, 0, 0};
      ov = 0;
      repeat (4 * len * dv) begin
         @(posedge core_clk_in);
         #1;
         ov += int'(shoot !== 1'b0);
         for (int i = 0; i < 3; i++) begin
            ha[i] += int'(hp[i] !== hi_opt);
            la[i] += int'(lp[i] !== lo_opt);
         end
      end
      check(ov, 0, "pair overlap");
      for (int i = 0; i < 3; i++) begin
         k = cfg[2 + i] + cfg[1];
         check(ha[i], 4 * dv * (cfg[7] != 0 ? 2 * cfg[2 + i] - 1 : cfg[2 + i]), "high on");
         check(la[i], 4 * dv * (cfg[7] != 0 ? 2 * (cfg[0] - k) + 1 : cfg[0] + 1 - k), "low on");
      end
   endtask
   task automatic do_reset(input logic h, input logic l, input logic e);
      @(posedge core_clk_in);
      rst_in <= 1'b1;
      hi_opt <= h;
      lo_opt <= l;
      en_opt <= e;
      repeat (3) @(posedge core_clk_in);
      #1;
      check({hs_oe, ls_oe}, 6'h00, "driven in reset");
      rst_in <= 1'b0;
      @(posedge core_clk_in);
      #1;
      check({hs_oe, ls_oe}, 6'h00, "driven at release");
      repeat (4) @(posedge core_clk_in);
      #1;
      check({hs_oe, ls_oe}, {6{e}}, "pin enables");
      if (e) begin
         check({hp, lp}, {{3{h}}, {3{l}}}, "off levels");
      end
   endtask
   task automatic s_regs();
      logic [15:0] d;
      rd_reg(porp_pkg::OFS_PERIOD, d);
      check(d, porp_pkg::PERIOD_RST, "period reset");
      @(posedge core_clk_in);
      #1;
      check(rdata, 16'h0000, "read data one cycle");
      rd_reg(porp_pkg::OFS_COUNT, d);
      check(d, 16'h0000, "count while stopped");
      rd_reg(porp_pkg::OFS_WAVE_CTL1, d);
      check(d, 16'h0000, "control reset");
      wr_reg(porp_pkg::OFS_DEADBAND, 16'h00a5);
      rd_reg(porp_pkg::OFS_DEADBAND, d);
      check(d, 16'h00a5, "shadow readback");
      rd_reg(8'h40, d);
      check(d, 16'h0000, "unmapped read");
      rd_reg(porp_pkg::OFS_WAVE_CTL0, d);
      check(d[porp_pkg::CTL0_MOTOR_OUTPUT_ENABLE_OPTION], en_opt, "enable flag");
      check(d[porp_pkg::CTL0_ACTIVE], 1'b0, "idle after reset");
   endtask
   task automatic s_hold();
      int t;
      load('{7, 1, 1, 2, 3, 0, 0, 0});
      apply(t);
      meas();
      load('{7, 2, 3, 4, 5, 0, 2, 0});
      wr_reg(porp_pkg::OFS_WAVE_CTL0, 16'h0001);
      repeat (40) @(posedge core_clk_in);
      meas();
      apply(t);
      meas();
   endtask
   task automatic s_clock_divide_select();
      int t;
      for (int p = 0; p < 4; p++) begin
         load('{3, 0, 1, 2, 3, 0, p, 0});
         apply(t);
         meas();
      end
   endtask
   task automatic s_rate();
      int t0, t1, w;
      for (int r = 0; r < 4; r++) begin
         load('{15, 1, 4, 8, 12, r, 0, 0});
         apply(t0);
         apply(t0);
         apply(t1);
         w = 16 * (1 << r);
         check(32'(t1 - t0 > w - 5 && t1 - t0 < w + 5), 32'h1, "reload spacing");
      end
   endtask
   task automatic s_center();
      int t;
      logic [15:0] d;
      load('{6, 1, 1, 2, 3, 1, 0, 1});
      apply(t);
      meas();
      rd_reg(porp_pkg::OFS_WAVE_CTL0, d);
      check(d[porp_pkg::CTL0_ACTIVE], 1'b1, "running flag");
      wr_reg(porp_pkg::OFS_WAVE_CTL0, 16'h0000);
      repeat (3) @(posedge core_clk_in);
      #1;
      check({hp, lp}, {{3{hi_opt}}, {3{lo_opt}}}, "off after stop");
      rd_reg(porp_pkg::OFS_COUNT, d);
      check(d, 16'h0000, "count after stop");
   endtask
   task automatic s_disabled();
      logic [15:0] d;
      wr_reg(porp_pkg::OFS_WAVE_CTL0, 16'h0003);
      repeat (20) @(posedge core_clk_in);
      #1;
      check({hs_oe, ls_oe}, 6'h00, "driven while disabled");
      rd_reg(porp_pkg::OFS_WAVE_CTL0, d);
      check(d[porp_pkg::CTL0_ACTIVE], 1'b0, "counting while disabled");
   endtask
   initial begin
      do_reset(1'b0, 1'b1, 1'b0);
      s_regs();
      s_disabled();
      for (int i = 0; i < 4; i++) begin
         do_reset(i[0], i[1], 1'b1);
      end
      s_regs();
      s_hold();
      s_clock_divide_select();
      s_rate();
      do_reset(1'b0, 1'b0, 1'b1);
      s_center();
      do_reset(1'b1, 1'b0, 1'b1);
      give_verdict();
   end
endmodule
`default_nettype wire
